// ===== bench/tcph_chk_assertions.sv
// Purpose: Port-level checks for tcph_top.
// Assumes: Bound to every tcph_top instance.
// Notes: Only ports are seen, so internal timers are judged by their effects.
`timescale 1ns/1ps
module tcph_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic sw_wr_en,
	input wire logic sw_rd_en,
	input wire logic [1:0] sw_idx,
	input wire logic [tcph_pkg::TCPH_REG_W-1:0] sw_wdata,
	input wire logic [tcph_pkg::TCPH_REG_W-1:0] sw_rdata,
	input wire logic sw_rvalid,
	// Mailbox
	input wire logic mbox_wr,
	input wire logic [7:0] mbox_cmd,
	input wire logic mbox_busy,
	// Power and lanes
	input wire logic aux_pwr_req_legacy,
	input wire logic aux_pwr_req_tunnel,
	input wire logic aux_pwr_state,
	input wire logic usbc_connector,
	input wire logic boot_reversal,
	input wire logic ctrl_lane_reverse,
	input wire logic safe_mode_exit_bit,
	input wire logic [tcph_pkg::TCPH_LANES-1:0] per_lane_enable_field,
	input wire logic cold_state
);
	import tcph_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic req = aux_pwr_req_legacy | aux_pwr_req_tunnel;
	wire logic wr_ctrl = sw_wr_en && sw_idx == TCPH_IDX_CTRL;
	AST_RVALID: assert property (sw_rd_en |-> ##2 sw_rvalid) else $error("read not answered");
	AST_COLD_RD: assert property (sw_rd_en ##1 cold_state |=> sw_rdata == TCPH_ALL_ONES) else $error("cold read");
	AST_COLD_WR: assert property (cold_state |=> $stable(safe_mode_exit_bit) && $stable(per_lane_enable_field))
		else $error("cold write landed");
	AST_SAFE_WR: assert property (wr_ctrl && !cold_state |=> safe_mode_exit_bit == $past(sw_wdata[0]))
		else $error("safe bit not written");
	AST_SAFE_HOLD: assert property (!wr_ctrl |=> $stable(safe_mode_exit_bit)) else $error("safe bit moved");
	AST_MLE_WR: assert property (sw_wr_en && sw_idx == TCPH_IDX_MLE && !cold_state
		|=> per_lane_enable_field == $past(sw_wdata[3:0])) else $error("lane enable not written");
	AST_REVERSE: assert property (ctrl_lane_reverse == (usbc_connector ? 1'h0 : boot_reversal))
		else $error("reversal owner wrong");
	AST_AUX_FALL: assert property (!req |=> !aux_pwr_state) else $error("aux state stuck");
	AST_AUX_RISE: assert property ($rose(aux_pwr_state) |-> $past(req, 50)) else $error("aux state early");
	AST_MBOX: assert property (mbox_wr && mbox_cmd != TCPH_CMD_COLD_EXIT && !mbox_busy |=> !mbox_busy)
		else $error("bad command taken");
	AST_MBOX_GO: assert property (mbox_wr && mbox_cmd == TCPH_CMD_COLD_EXIT && cold_state |=> mbox_busy && !cold_state)
		else $error("exit command not taken");
endmodule // tcph_chk
bind tcph_top tcph_chk u_chk (
	.sys_clk(sys_clk),
	.rst(rst),
	.sw_wr_en(sw_wr_en),
	.sw_rd_en(sw_rd_en),
	.sw_idx(sw_idx),
	.sw_wdata(sw_wdata),
	.sw_rdata(sw_rdata),
	.sw_rvalid(sw_rvalid),
	.mbox_wr(mbox_wr),
	.mbox_cmd(mbox_cmd),
	.mbox_busy(mbox_busy),
	.aux_pwr_req_legacy(aux_pwr_req_legacy),
	.aux_pwr_req_tunnel(aux_pwr_req_tunnel),
	.aux_pwr_state(aux_pwr_state),
	.usbc_connector(usbc_connector),
	.boot_reversal(boot_reversal),
	.ctrl_lane_reverse(ctrl_lane_reverse),
	.safe_mode_exit_bit(safe_mode_exit_bit),
	.per_lane_enable_field(per_lane_enable_field),
	.cold_state(cold_state)
);

// ===== bench/tcph_fw_model.sv
// Purpose: Firmware model driving the status side of tcph_top.
// Assumes: Bench commands change just after a clock edge.
// Notes: The lane assignment value is arbitrary; cold is asked for blindly so the device must refuse it during hold-off.
`timescale 1ns/1ps
module tcph_fw_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bench commands
	input wire logic want_cold,
	input wire logic [1:0] conn,
	// Firmware outputs
	output logic fw_cold_req,
	output logic fw_phy_dp_mode,
	output logic [1:0] fw_live_state,
	output logic [3:0] fw_lane_assign
);
	import tcph_pkg::*;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fw_cold_req <= 1'h0;
			fw_phy_dp_mode <= 1'h0;
			fw_live_state <= TCPH_LIVE_NONE;
			fw_lane_assign <= 4'h0;
		end else begin
			fw_cold_req <= want_cold;
			fw_live_state <= conn;
			fw_phy_dp_mode <= conn == TCPH_LIVE_NATIVE;
			fw_lane_assign <= (conn == TCPH_LIVE_NATIVE) ? 4'h3 : 4'h0;
		end
	end
endmodule // tcph_fw_model

// ===== bench/tcph_top_test.sv
// Purpose: Self-checking bench for tcph_top.
// Assumes: Firmware model on the status side.
// Notes: The mailbox hold-off would outlast the run, so the mid-run reset is what ends it.
`timescale 1ns/1ps
module tcph_top_test;
	import tcph_pkg::*;
	typedef struct packed {logic w; logic [1:0] i; logic [1:0] c; logic [31:0] d; logic [31:0] e;} tcph_row_t;
	logic sys_clk = 0, rst = 1, we = 0, re = 0, mw = 0, ul = 0, ut = 0, uc = 0, br = 0, wc = 0;
	logic [1:0] idx = 0, cn = 0;
	logic [7:0] mc = 0;
	logic [31:0] wd = 0, rd;
	logic rv, bz, cr, ps, rvs, sb, cs, dp;
	logic [1:0] ls;
	logic [3:0] la, le;
	int errors = 0, cmp_count = 0, n;
	tcph_row_t rows [7] = '{
		'{1'h1, 2'h0, 2'h0, 32'h0000_0001, 32'h0000_0001},
		'{1'h1, 2'h3, 2'h0, 32'h0000_0005, 32'h0000_0005},
		'{1'h0, 2'h1, 2'h1, 32'h0000_0000, 32'h0000_0001},
		'{1'h0, 2'h2, 2'h1, 32'h0000_0000, 32'h0000_0031},
		'{1'h0, 2'h2, 2'h2, 32'h0000_0000, 32'h0000_0002},
		'{1'h0, 2'h1, 2'h2, 32'h0000_0000, 32'h0000_0000},
		'{1'h1, 2'h0, 2'h0, 32'h0000_0000, 32'h0000_0000}};
	tcph_top DUT (.sys_clk(sys_clk), .rst(rst), .sw_wr_en(we), .sw_rd_en(re), .sw_idx(idx), .sw_wdata(wd),
		.sw_rdata(rd), .sw_rvalid(rv), .mbox_wr(mw), .mbox_cmd(mc), .mbox_busy(bz), .fw_cold_req(cr),
		.fw_phy_dp_mode(dp), .fw_live_state(ls), .fw_lane_assign(la), .aux_pwr_req_legacy(ul),
		.aux_pwr_req_tunnel(ut), .aux_pwr_state(ps), .usbc_connector(uc), .boot_reversal(br),
		.ctrl_lane_reverse(rvs), .safe_mode_exit_bit(sb), .per_lane_enable_field(le), .cold_state(cs));
	tcph_fw_model u_fw (.sys_clk(sys_clk), .rst(rst), .want_cold(wc), .conn(cn), .fw_cold_req(cr),
		.fw_phy_dp_mode(dp), .fw_live_state(ls), .fw_lane_assign(la));
	initial forever #10 sys_clk = ~sys_clk;
	task automatic final_report();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [1:0] i, input logic [31:0] d);
		tick(1);
		we = 1;
		idx = i;
		wd = d;
		tick(1);
		we = 0;
	endtask
	task automatic rdk(input logic [1:0] i, input logic [31:0] e);
		tick(1);
		re = 1;
		idx = i;
		tick(1);
		re = 0;
		tick(1);
		chk_bit(rv, 1'h1);
		chk_word(rd, e);
	endtask
	// A wait that runs out ends the run at once, since later steps would only cascade.
	task automatic wait_on(input logic [1:0] k, input logic v, input int lim);
		n = 0;
		while ((k == 2'h2 ? bz : (k[0] ? ps : cs)) !== v) begin
			tick(1);
			n++;
			if (n > lim) begin
				errors++;
				final_report();
			end
		end
	endtask
	initial begin
		tick(8);
		rst = 0;
		tick(3);
		foreach (rows[k]) begin
			cn = rows[k].c;
			if (rows[k].w) wr(rows[k].i, rows[k].d);
			tick(2);
			rdk(rows[k].i, rows[k].e);
		end
		chk_word({28'h0, le}, 32'h0000_0005);
		$display("Test register table done");
		for (int k = 0; k < 4; k++) begin
			uc = k[0];
			br = k[1];
			tick(1);
			chk_bit(rvs, k[0] ? 1'h0 : k[1]);
		end
		$display("Test lane reversal done");
		for (int k = 0; k < 2; k++) begin
			ul = k == 0;
			ut = k == 1;
			wait_on(1, 1, 500);
			chk_word(32'(n), 32'(TCPH_AUX_SETTLE_CYC));
			ul = 0;
			ut = 0;
			tick(2);
			chk_bit(ps, 1'h0);
		end
		$display("Test aux power done");
		wr(0, 32'h0000_0001);
		wc = 1;
		tick(30);
		chk_bit(cs, 1'h0);
		cn = 2;
		tick(3);
		chk_bit(sb, 1'h1);
		wr(0, 32'h0000_0000);
		wait_on(0, 1, 100);
		rdk(0, TCPH_ALL_ONES);
		rdk(3, TCPH_ALL_ONES);
		wr(0, 32'h0000_0001);
		chk_bit(sb, 1'h0);
		mw = 1;
		mc = 8'h34;
		tick(1);
		mw = 0;
		tick(3);
		chk_bit(bz, 1'h0);
		wc = 0;
		wait_on(0, 0, 100);
		rdk(0, 32'h0000_0000);
		wc = 1;
		wait_on(0, 1, 100);
		mw = 1;
		mc = TCPH_CMD_COLD_EXIT;
		tick(1);
		mw = 0;
		chk_bit(bz, 1'h1);
		wait_on(2, 0, 50_100);
		chk_word(32'(n), 32'(TCPH_EXIT_CYC));
		chk_bit(cs, 1'h0);
		tick(10);
		chk_bit(cs, 1'h0);
		$display("Test cold state done");
		wr(0, 32'h0000_0001);
		rst = 1;
		tick(2);
		chk_bit(sb, 1'h0);
		chk_word({28'h0, le}, 32'h0000_000F);
		chk_word(rd, TCPH_ALL_ONES);
		chk_bit(cs, 1'h1);
		rst = 0;
		tick(1);
		chk_bit(cs, 1'h0);
		tick(1);
		chk_bit(cs, 1'h1);
		$display("Test mid-run reset done");
		final_report();
	end
endmodule // tcph_top_test

// ===== design/tcph_regs.sv
// Purpose: Four-word register store with registered read data.
// Assumes: Single write and single read port, same clock.
// Notes: Read data lag the address by one cycle.
`timescale 1ns/1ps
module tcph_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [tcph_pkg::TCPH_REG_W-1:0] wr_data,
	// Read port
	input wire logic [1:0] rd_idx,
	output logic [tcph_pkg::TCPH_REG_W-1:0] rd_data,
	// Direct view of the control and lane-enable words
	output logic [tcph_pkg::TCPH_REG_W-1:0] word_ctrl,
	output logic [tcph_pkg::TCPH_REG_W-1:0] word_mle
);
	import tcph_pkg::*;
	logic [TCPH_REG_W-1:0] mem_q [4];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_word
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					mem_q[g] <= (g == TCPH_IDX_MLE) ? {{(TCPH_REG_W-TCPH_LANES){1'b0}}, TCPH_MLE_RST} : TCPH_CTRL_RST;
				end else if (wr_en && wr_idx == 2'(g)) begin
					mem_q[g] <= wr_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= TCPH_CTRL_RST;
		end else begin
			rd_data <= mem_q[rd_idx];
		end
	end

	assign word_ctrl = mem_q[TCPH_IDX_CTRL];
	assign word_mle = mem_q[TCPH_IDX_MLE];
endmodule // tcph_regs

// ===== design/tcph_top.sv
// Purpose: Device side of the USB-C display port connect handshake.
// Assumes: Inputs synchronous to sys_clk; firmware drives phy mode, live state and lane assignment.
// Notes: Register access is a simple indexed port; read data arrive two cycles after sw_rd_en.
`timescale 1ns/1ps
module tcph_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Software register port
	input wire logic sw_wr_en,
	input wire logic sw_rd_en,
	input wire logic [1:0] sw_idx,
	input wire logic [tcph_pkg::TCPH_REG_W-1:0] sw_wdata,
	output logic [tcph_pkg::TCPH_REG_W-1:0] sw_rdata,
	output logic sw_rvalid,
	// Software cold-exit mailbox
	input wire logic mbox_wr,
	input wire logic [7:0] mbox_cmd,
	output logic mbox_busy,
	// Firmware side status
	input wire logic fw_cold_req,
	input wire logic fw_phy_dp_mode,
	input wire logic [1:0] fw_live_state,
	input wire logic [3:0] fw_lane_assign,
	// AUX power
	input wire logic aux_pwr_req_legacy,
	input wire logic aux_pwr_req_tunnel,
	output logic aux_pwr_state,
	// Lane reversal
	input wire logic usbc_connector,
	input wire logic boot_reversal,
	output logic ctrl_lane_reverse,
	// Outputs to firmware and lane mux
	output logic safe_mode_exit_bit,
	output logic [tcph_pkg::TCPH_LANES-1:0] per_lane_enable_field,
	output logic cold_state
);
	import tcph_pkg::*;

	tcph_pwr_t pwr_q;
	logic [TCPH_CNT_W-1:0] tmr_q;
	logic [TCPH_AUX_CNT_W-1:0] aux_cnt_q;
	logic aux_req;
	logic cold;
	logic wr_ok;
	logic rd_q;
	logic [1:0] rd_idx_q;
	logic [TCPH_REG_W-1:0] mem_rd;
	logic [TCPH_REG_W-1:0] word_ctrl;
	logic [TCPH_REG_W-1:0] word_mle;
	logic [TCPH_REG_W-1:0] status_word;

	function automatic logic hold_off(input logic [TCPH_REG_W-1:0] ctrl, input logic areq);
		// Safe-mode exit or AUX power request keeps the subsystem out of the cold state.
		hold_off = ctrl[TCPH_SAFE_EXIT_BIT] | areq;
	endfunction

	assign aux_req = aux_pwr_req_legacy | aux_pwr_req_tunnel;
	assign cold = (pwr_q == TCPH_COLD);
	assign wr_ok = sw_wr_en && !cold; // R22

	// Cold state machine; a mailbox exit holds the block awake for the hold-off window.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwr_q <= TCPH_COLD;
			tmr_q <= '0;
		end else begin
			unique case (pwr_q)
				TCPH_COLD: begin
					if (mbox_wr && mbox_cmd == TCPH_CMD_COLD_EXIT) begin // R23
						pwr_q <= TCPH_EXITING;
						tmr_q <= TCPH_CNT_W'(TCPH_EXIT_CYC - 1);
					end else if (!fw_cold_req) begin
						pwr_q <= TCPH_AWAKE;
						tmr_q <= '0;
					end
				end
				TCPH_EXITING: begin
					if (tmr_q == '0) begin
						pwr_q <= TCPH_AWAKE;
						tmr_q <= TCPH_CNT_W'(TCPH_HOLD_CYC - 1); // R12
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				TCPH_AWAKE: begin
					if (tmr_q != '0) begin
						tmr_q <= tmr_q - 1'b1;
					end else if (fw_cold_req && !hold_off(word_ctrl, aux_req)) begin // R18
						pwr_q <= TCPH_COLD;
					end
				end
				default: begin
					pwr_q <= TCPH_COLD;
					tmr_q <= '0;
				end
			endcase
		end
	end

	// The busy flag clears once the exit completes, a full 1 ms after the command, equal to the 1 ms poll limit.
	assign mbox_busy = (pwr_q == TCPH_EXITING); // R23

	tcph_regs u_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(wr_ok),
		.wr_idx(sw_idx),
		.wr_data(sw_wdata),
		.rd_idx(sw_idx),
		.rd_data(mem_rd),
		.word_ctrl(word_ctrl),
		.word_mle(word_mle)
	);

	// Status words are built live from the firmware inputs.
	always_comb begin
		status_word = '0;
		unique case (rd_idx_q)
			TCPH_IDX_PMS: status_word[TCPH_PHY_MODE_BIT] = fw_phy_dp_mode; // R03
			TCPH_IDX_LIVE: begin
				status_word[TCPH_LIVE_LSB +: 2] = fw_live_state;
				status_word[TCPH_LANE_LSB +: 4] = fw_lane_assign;
			end
			default: status_word = mem_rd;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_q <= 1'b0;
			rd_idx_q <= TCPH_IDX_CTRL;
		end else begin
			rd_q <= sw_rd_en;
			rd_idx_q <= sw_idx;
		end
	end

	// Status is sampled at the read edge so a cold entry in between still reads all ones.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_rdata <= TCPH_ALL_ONES;
		end else if (rd_q) begin
			sw_rdata <= cold ? TCPH_ALL_ONES : status_word; // R22
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_rvalid <= 1'b0;
		end else begin
			sw_rvalid <= rd_q;
		end
	end

	// AUX power state follows the request after a short settle, and never in cold state.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aux_cnt_q <= '0;
		end else if (!aux_req || cold) begin
			aux_cnt_q <= '0;
		end else if (aux_cnt_q != TCPH_AUX_CNT_W'(TCPH_AUX_SETTLE_CYC)) begin
			aux_cnt_q <= aux_cnt_q + 1'b1;
		end
	end

	assign aux_pwr_state = (aux_cnt_q == TCPH_AUX_CNT_W'(TCPH_AUX_SETTLE_CYC)); // R13

	// Held value is the software copy only; firmware inputs never touch it.
	assign safe_mode_exit_bit = word_ctrl[TCPH_SAFE_EXIT_BIT]; // R05 R24
	assign per_lane_enable_field = word_mle[TCPH_MLE_LSB +: TCPH_LANES];
	assign cold_state = cold;
	// With a USB-C connector the mux reverses, so the controller stays unreversed.
	assign ctrl_lane_reverse = usbc_connector ? 1'b0 : boot_reversal; // R21
endmodule // tcph_top

// ===== include/tcph_pkg.sv
// Purpose: Constants and types for the USB-C display port connect handshake block.
// Assumes: One 50 MHz clock, asynchronous active-high reset.
// Notes: Behaviour list below; tags mark the logic in the design files.
//
// Behaviour
// R01 - Software clears safe-mode-exit bit when not using main link or AUX, then aborts.
// R02 - Software reads control register first; all ones means powered down, no write.
// R03 - Device reports PHY-mode status one once firmware switched lane to DP mode.
// R04 - PHY-mode status reading all ones means disconnected; software aborts connect.
// R05 - Software sets safe-mode-exit bit; device holds and presents it to firmware.
// R06 - Live connection state reading all ones means nothing connected; software aborts.
// R07 - No connection of either kind: software clears bit, skipping write if all ones.
// R08 - Tunneled connection: software clears bit and follows tunneled flow.
// R09 - Native USB-C: software continues, reads lane assignment for maximum lane count.
// R10 - DP alternate and static: AUX select legacy, power via non-tunneled request.
// R11 - Tunneled: AUX select tunnel path, power via tunnel request.
// R12 - Static flow: cold exit command, then finish steps within 500 ms.
// R13 - Static flow: device asserts AUX power state; software fails after 10 us.
// R14 - Static HDMI assumes four lanes; static DP derives lanes from sink data.
// R15 - Software gives early disconnect before long non-serviceable sleep states.
// R16 - Disconnect: mode-set disable, then AUX power off; keep AUX select unchanged.
// R17 - Non-tunneled disconnect clears safe-mode-exit bit; skip if register reads all ones.
// R18 - Static disconnect: cold exit command, then clear bit within 500 ms.
// R19 - Software finishes disconnect before starting any connect flow.
// R20 - Software turns off assigned but unused lanes via per-lane enable field.
// R21 - USB-C reversal done by lane mux; legacy reversal by buffer control boot setting.
// R22 - In cold state, mux and PHY register reads return all ones, writes ignored.
// R23 - Cold exit: mailbox run/busy with command 0x12, poll 1 ms, then wait 1 ms.
// R24 - Device holds safe-mode-exit bit as last written, unaffected by firmware status.
package tcph_pkg;
	localparam int unsigned TCPH_CLK_HZ = 50_000_000;
	localparam int unsigned TCPH_REG_W = 32;
	localparam int unsigned TCPH_LANES = 4;
	localparam logic [TCPH_REG_W-1:0] TCPH_ALL_ONES = 32'hFFFF_FFFF;
	// Register indices inside the little register array.
	localparam logic [1:0] TCPH_IDX_CTRL = 2'h0;
	localparam logic [1:0] TCPH_IDX_PMS = 2'h1;
	localparam logic [1:0] TCPH_IDX_LIVE = 2'h2;
	localparam logic [1:0] TCPH_IDX_MLE = 2'h3;
	// Field positions.
	localparam int unsigned TCPH_SAFE_EXIT_BIT = 0;
	localparam int unsigned TCPH_PHY_MODE_BIT = 0;
	localparam int unsigned TCPH_LIVE_LSB = 0;
	localparam int unsigned TCPH_LANE_LSB = 4;
	localparam int unsigned TCPH_MLE_LSB = 0;
	// Live connection codes.
	localparam logic [1:0] TCPH_LIVE_NONE = 2'h0;
	localparam logic [1:0] TCPH_LIVE_NATIVE = 2'h1;
	localparam logic [1:0] TCPH_LIVE_TUNNEL = 2'h2;
	// Reset values.
	localparam logic [TCPH_REG_W-1:0] TCPH_CTRL_RST = 32'h0000_0000;
	localparam logic [TCPH_LANES-1:0] TCPH_MLE_RST = 4'hF;
	// AUX power settle: state follows request after this time.
	localparam int unsigned TCPH_AUX_SETTLE_NS = 1000;
	localparam int unsigned TCPH_AUX_SETTLE_CYC = TCPH_AUX_SETTLE_NS / (1_000_000_000 / TCPH_CLK_HZ);
	localparam int unsigned TCPH_AUX_CNT_W = 8;
	// Cold exit holds off re-entry for this long.
	localparam int unsigned TCPH_HOLD_MS = 500;
	localparam int unsigned TCPH_HOLD_CYC = TCPH_HOLD_MS * (TCPH_CLK_HZ / 1000);
	localparam int unsigned TCPH_EXIT_MS = 1;
	localparam int unsigned TCPH_EXIT_CYC = TCPH_EXIT_MS * (TCPH_CLK_HZ / 1000);
	localparam int unsigned TCPH_CNT_W = 25;
	localparam logic [7:0] TCPH_CMD_COLD_EXIT = 8'h12;

	typedef enum logic [2:0] {
		TCPH_COLD = 3'b001,
		TCPH_EXITING = 3'b010,
		TCPH_AWAKE = 3'b100
	} tcph_pwr_t;
endpackage
